// ===== hdl/isam_top.sv
// Overview of operation
// - Stop flag set when stop came last.
// - Start flag set when start came last.
// - Start, restart, stop all update both flags.
// - Direction flag: one read, zero write.
// - Direction updated only after address byte.
// - Receive full set when byte enters buffer.
// - Reading receive buffer clears receive full.
// - Writing transmit buffer when not busy sets transmit full.
// - Transmit full clears when byte sent.
// - Mask bit one ignores address bit.
// - Mask bit zero requires address bit equal.
// - Mask upper twenty-two bits read zero.
//
// Purpose: Status flags, address mask and a small slave byte engine.
// Assumes: AHB-Lite slave, single word transfers; SCL and SDA sampled on clk.
// Notes:   Seven-bit slave addressing is matched against the ten-bit mask.
`timescale 1ns/100ps
module isam_top (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        scl_in,
    input  wire logic        sda_in,
    output logic             sda_o,
    output logic             sda_oe_n,
    output logic             irq
);

    //////////////////////////////////////////////////////////////////////////////
    // Declarations.
    logic                               wr_pend_reg;
    logic                               rd_pend_reg;
    logic [7:0]                         acc_addr_reg;
    logic [31:0]                        hrdata_reg;
    logic [31:0]                        rd_mux;
    logic                               take;
    logic                               wr_status;
    logic                               wr_mask;
    logic                               wr_tx;
    logic                               wr_own;
    logic                               wr_irqstat;
    logic                               wr_irqmask;
    logic                               rd_rx;
    logic [isam_pkg::MASK_W-1:0]        mask_reg;
    logic [isam_pkg::MASK_W-1:0]        own_reg;
    logic [isam_pkg::BYTE_W-1:0]        rxbuf_reg;
    logic [isam_pkg::BYTE_W-1:0]        txbuf_reg;
    logic [isam_pkg::BYTE_W-1:0]        rsr_reg;
    logic [isam_pkg::BYTE_W-1:0]        txsh_reg;
    logic [isam_pkg::BYTE_W-1:0]        byte_in;
    logic [3:0]                         bitcnt_reg;
    logic                               rbf_reg;
    logic                               tbf_reg;
    logic                               rw_reg;
    logic                               da_reg;
    logic                               s_reg;
    logic                               p_reg;
    logic                               ov_reg;
    logic                               wcol_reg;
    logic                               ack_pend_reg;
    logic                               drive_low_reg;
    logic [isam_pkg::IRQ_W-1:0]         irq_stat_reg;
    logic [isam_pkg::IRQ_W-1:0]         irq_mask_reg;
    logic [isam_pkg::IRQ_W-1:0]         irq_ev;
    logic [isam_pkg::STAT_W-1:0]        status;
    isam_pkg::isam_state_e              state_reg;
    logic                               scl_rise;
    logic                               scl_fall;
    logic                               start_seen;
    logic                               stop_seen;
    logic                               sda_now;
    logic                               byte_done;
    logic                               addr_hit;
    logic                               rx_load;
    logic                               rx_over;
    logic                               tx_busy;
    logic                               tx_done;

    //////////////////////////////////////////////////////////////////////////////
    // Pin front end and address comparator.
    isam_cond_detect u_cond (
        .clk        (clk),
        .rst        (rst),
        .scl_in     (scl_in),
        .sda_in     (sda_in),
        .scl_rise   (scl_rise),
        .scl_fall   (scl_fall),
        .start_seen (start_seen),
        .stop_seen  (stop_seen),
        .sda_now    (sda_now)
    );

    isam_addr_match u_match (
        .in_addr   ({3'h0, byte_in[7:1]}),
        .own_addr  (own_reg),
        .addr_mask (mask_reg),
        .match     (addr_hit)
    );

    //////////////////////////////////////////////////////////////////////////////
    // Bus slave. Writes finish in their data phase; reads take one wait state so
    // that a read straight after a write always sees the written value.
    assign take      = hsel & hready & htrans[1];
    assign hreadyout = ~rd_pend_reg;
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_reg;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_pend_reg  <= 1'b0;
            rd_pend_reg  <= 1'b0;
            acc_addr_reg <= 8'h00;
        end else begin
            wr_pend_reg <= take & hwrite;
            rd_pend_reg <= take & ~hwrite;
            if (take) begin
                acc_addr_reg <= haddr[7:0];
            end
        end
    end

    assign wr_status  = wr_pend_reg & (acc_addr_reg == isam_pkg::OFF_STATUS);
    assign wr_mask    = wr_pend_reg & (acc_addr_reg == isam_pkg::OFF_MASK);
    assign wr_tx      = wr_pend_reg & (acc_addr_reg == isam_pkg::OFF_TXBUF);
    assign wr_own     = wr_pend_reg & (acc_addr_reg == isam_pkg::OFF_OWNADDR);
    assign wr_irqstat = wr_pend_reg & (acc_addr_reg == isam_pkg::OFF_IRQSTAT);
    assign wr_irqmask = wr_pend_reg & (acc_addr_reg == isam_pkg::OFF_IRQMASK);
    assign rd_rx      = rd_pend_reg & (acc_addr_reg == isam_pkg::OFF_RXBUF);

    always_comb begin
        status = '0;
        status[isam_pkg::STAT_TBF]  = tbf_reg;
        status[isam_pkg::STAT_RBF]  = rbf_reg;
        status[isam_pkg::STAT_RW]   = rw_reg;
        status[isam_pkg::STAT_S]    = s_reg;
        status[isam_pkg::STAT_P]    = p_reg;
        status[isam_pkg::STAT_DA]   = da_reg;
        status[isam_pkg::STAT_OV]   = ov_reg;
        status[isam_pkg::STAT_WCOL] = wcol_reg;
    end

    always_comb begin
        unique case (acc_addr_reg)
            isam_pkg::OFF_STATUS:  rd_mux = {24'h000000, status};
            isam_pkg::OFF_MASK:    rd_mux = {22'h0, mask_reg};
            isam_pkg::OFF_TXBUF:   rd_mux = {24'h000000, txbuf_reg};
            isam_pkg::OFF_RXBUF:   rd_mux = {24'h000000, rxbuf_reg};
            isam_pkg::OFF_OWNADDR: rd_mux = {22'h0, own_reg};
            isam_pkg::OFF_IRQSTAT: rd_mux = {26'h0, irq_stat_reg};
            isam_pkg::OFF_IRQMASK: rd_mux = {26'h0, irq_mask_reg};
            default:               rd_mux = 32'h00000000;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hrdata_reg <= 32'h00000000;
        end else if (rd_pend_reg) begin
            hrdata_reg <= rd_mux;
        end
    end

    //////////////////////////////////////////////////////////////////////////////
    // Configuration registers.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mask_reg     <= isam_pkg::MASK_RST;
            own_reg      <= isam_pkg::OWNADDR_RST;
            irq_mask_reg <= isam_pkg::IRQ_RST;
        end else begin
            if (wr_mask) begin
                mask_reg <= hwdata[isam_pkg::MASK_W-1:0];
            end
            if (wr_own) begin
                own_reg <= hwdata[isam_pkg::MASK_W-1:0];
            end
            if (wr_irqmask) begin
                irq_mask_reg <= hwdata[isam_pkg::IRQ_W-1:0];
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////////
    // Link byte engine. A start or stop always wins over bit activity.
    assign byte_in   = {rsr_reg[6:0], sda_now};
    assign byte_done = scl_rise & (bitcnt_reg == isam_pkg::BIT_LAST)
                     & (state_reg != isam_pkg::ST_IDLE) & (state_reg != isam_pkg::ST_SKIP);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg  <= isam_pkg::ST_IDLE;
            bitcnt_reg <= 4'h0;
            rsr_reg    <= isam_pkg::BUF_RST;
        end else if (start_seen) begin
            state_reg  <= isam_pkg::ST_ADDR;
            bitcnt_reg <= 4'h0;
        end else if (stop_seen) begin
            state_reg  <= isam_pkg::ST_IDLE;
            bitcnt_reg <= 4'h0;
        end else if (scl_rise && state_reg != isam_pkg::ST_IDLE) begin
            if (bitcnt_reg == isam_pkg::BIT_ACK) begin
                bitcnt_reg <= 4'h0;
                // A master that refuses a read byte ends the read.
                if (state_reg == isam_pkg::ST_RDATA && sda_now) begin
                    state_reg <= isam_pkg::ST_SKIP;
                end
            end else begin
                bitcnt_reg <= bitcnt_reg + 4'h1;
                rsr_reg    <= byte_in;
            end
            if (byte_done && state_reg == isam_pkg::ST_ADDR) begin
                if (!addr_hit) begin
                    state_reg <= isam_pkg::ST_SKIP;
                end else if (byte_in[0]) begin
                    state_reg <= isam_pkg::ST_RDATA;
                end else begin
                    state_reg <= isam_pkg::ST_WDATA;
                end
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////////
    // Bus condition flags.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_reg <= 1'b0;
            p_reg <= 1'b0;
        end else if (start_seen) begin
            s_reg <= 1'b1;
            p_reg <= 1'b0;
        end else if (stop_seen) begin
            s_reg <= 1'b0;
            p_reg <= 1'b1;
        end
    end

    // Direction and byte kind.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rw_reg <= 1'b0;
            da_reg <= 1'b0;
        end else if (byte_done) begin
            if (state_reg == isam_pkg::ST_ADDR) begin
                da_reg <= 1'b0;
                if (addr_hit) begin
                    rw_reg <= byte_in[0];
                end
            end else if (state_reg == isam_pkg::ST_WDATA) begin
                da_reg <= 1'b1;
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////////
    // Receive holding buffer. An unread byte is kept; the new one is dropped.
    assign rx_load = byte_done & ((state_reg == isam_pkg::ST_WDATA)
                   | ((state_reg == isam_pkg::ST_ADDR) & addr_hit));
    assign rx_over = rx_load & rbf_reg;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rxbuf_reg <= isam_pkg::BUF_RST;
            rbf_reg   <= 1'b0;
            ov_reg    <= 1'b0;
        end else begin
            if (rx_load && !rbf_reg) begin
                rxbuf_reg <= byte_in;
                rbf_reg   <= 1'b1;
            end else if (rd_rx) begin
                rbf_reg <= 1'b0;
            end
            if (rx_over) begin
                ov_reg <= 1'b1;
            end else if (wr_status && hwdata[isam_pkg::STAT_OV]) begin
                ov_reg <= 1'b0;
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////////
    // Transmit buffer. Busy means a byte is waiting or is being shifted out.
    assign tx_busy = tbf_reg | ((state_reg == isam_pkg::ST_RDATA) & (bitcnt_reg != 4'h0));
    assign tx_done = byte_done & (state_reg == isam_pkg::ST_RDATA);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            txbuf_reg <= isam_pkg::BUF_RST;
            tbf_reg   <= 1'b0;
            wcol_reg  <= 1'b0;
        end else begin
            if (wr_tx && !tx_busy) begin
                txbuf_reg <= hwdata[isam_pkg::BYTE_W-1:0];
                tbf_reg   <= 1'b1;
            end else if (tx_done) begin
                tbf_reg <= 1'b0;
            end
            if (wr_tx && tx_busy) begin
                wcol_reg <= 1'b1;
            end else if (wr_status && hwdata[isam_pkg::STAT_WCOL]) begin
                wcol_reg <= 1'b0;
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////////
    // Serial data drive: acknowledge and read data, changed on SCL falling.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            txsh_reg      <= isam_pkg::BUF_RST;
            ack_pend_reg  <= 1'b0;
            drive_low_reg <= 1'b0;
        end else if (start_seen || stop_seen) begin
            ack_pend_reg  <= 1'b0;
            drive_low_reg <= 1'b0;
        end else begin
            if (byte_done) begin
                ack_pend_reg <= rx_load;
            end
            if (scl_rise && bitcnt_reg == isam_pkg::BIT_ACK) begin
                txsh_reg <= txbuf_reg;
            end else if (byte_done && state_reg == isam_pkg::ST_ADDR) begin
                txsh_reg <= txbuf_reg;
            end
            if (scl_fall) begin
                if (bitcnt_reg == isam_pkg::BIT_ACK) begin
                    drive_low_reg <= ack_pend_reg;
                end else if (state_reg == isam_pkg::ST_RDATA) begin
                    drive_low_reg <= ~txsh_reg[3'h7 - bitcnt_reg[2:0]];
                end else begin
                    drive_low_reg <= 1'b0;
                end
            end
        end
    end

    assign sda_o    = 1'b0;
    assign sda_oe_n = ~drive_low_reg;

    //////////////////////////////////////////////////////////////////////////////
    // Interrupts. A new event wins over a clear written in the same cycle.
    always_comb begin
        irq_ev = '0;
        irq_ev[isam_pkg::IRQ_START] = start_seen;
        irq_ev[isam_pkg::IRQ_STOP]  = stop_seen;
        irq_ev[isam_pkg::IRQ_RX]    = rx_load & ~rbf_reg;
        irq_ev[isam_pkg::IRQ_TXD]   = tx_done;
        irq_ev[isam_pkg::IRQ_WCOL]  = wr_tx & tx_busy;
        irq_ev[isam_pkg::IRQ_OV]    = rx_over;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq_stat_reg <= isam_pkg::IRQ_RST;
        end else if (wr_irqstat) begin
            irq_stat_reg <= (irq_stat_reg & ~hwdata[isam_pkg::IRQ_W-1:0]) | irq_ev;
        end else begin
            irq_stat_reg <= irq_stat_reg | irq_ev;
        end
    end

    assign irq = |(irq_stat_reg & irq_mask_reg);

    // Transfer size is not checked: every access is taken as a whole word.
    logic unused_size;
    assign unused_size = |hsize;

endmodule

// ===== hdl/isam_pkg.sv
// Purpose: Shared constants for the serial bus status and address mask block.
// Assumes: AHB-Lite register access, one register per aligned 32-bit word.
// Notes:   Offsets are byte addresses on the register bus.
package isam_pkg;

    //////////////////////////////////////////////////////////////////////////////
    // Register offsets.
    localparam logic [7:0] OFF_STATUS   = 8'h00;
    localparam logic [7:0] OFF_MASK     = 8'h04;
    localparam logic [7:0] OFF_TXBUF    = 8'h08;
    localparam logic [7:0] OFF_RXBUF    = 8'h0c;
    localparam logic [7:0] OFF_OWNADDR  = 8'h10;
    localparam logic [7:0] OFF_IRQSTAT  = 8'h14;
    localparam logic [7:0] OFF_IRQMASK  = 8'h18;

    //////////////////////////////////////////////////////////////////////////////
    // Status field positions.
    localparam int STAT_TBF  = 0;
    localparam int STAT_RBF  = 1;
    localparam int STAT_RW   = 2;
    localparam int STAT_S    = 3;
    localparam int STAT_P    = 4;
    localparam int STAT_DA   = 5;
    localparam int STAT_OV   = 6;
    localparam int STAT_WCOL = 7;
    localparam int STAT_W    = 8;

    // Interrupt event positions.
    localparam int IRQ_START = 0;
    localparam int IRQ_STOP  = 1;
    localparam int IRQ_RX    = 2;
    localparam int IRQ_TXD   = 3;
    localparam int IRQ_WCOL  = 4;
    localparam int IRQ_OV    = 5;
    localparam int IRQ_W     = 6;

    //////////////////////////////////////////////////////////////////////////////
    // Widths, counts and reset values.
    localparam int MASK_W    = 10;
    localparam int BYTE_W    = 8;
    localparam logic [3:0] BIT_LAST = 4'h7;
    localparam logic [3:0] BIT_ACK  = 4'h8;
    localparam logic [MASK_W-1:0] MASK_RST    = 10'h000;
    localparam logic [MASK_W-1:0] OWNADDR_RST = 10'h000;
    localparam logic [BYTE_W-1:0] BUF_RST     = 8'h00;
    localparam logic [IRQ_W-1:0]  IRQ_RST     = 6'h00;

    // Link states.
    typedef enum logic [4:0] {
        ST_IDLE  = 5'b00001,
        ST_ADDR  = 5'b00010,
        ST_WDATA = 5'b00100,
        ST_RDATA = 5'b01000,
        ST_SKIP  = 5'b10000
    } isam_state_e;

endpackage

// ===== hdl/isam_cond_detect.sv
// Purpose: Synchronise the bus pins and find clock edges, start and stop.
// Assumes: Pins are asynchronous to clk and much slower than it.
// Notes:   All outputs but sda_now are one-cycle pulses on clk; sda_now is the synchronised SDA level.
`timescale 1ns/100ps
module isam_cond_detect (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic scl_in,
    input  wire logic sda_in,
    output logic      scl_rise,
    output logic      scl_fall,
    output logic      start_seen,
    output logic      stop_seen,
    output logic      sda_now
);

    logic [1:0] scl_sync_reg;
    logic [1:0] sda_sync_reg;
    logic       scl_prev_reg;
    logic       sda_prev_reg;

    //////////////////////////////////////////////////////////////////////////////
    // Only the second stage is read, to keep metastability out of the logic.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            scl_sync_reg <= 2'h3;
            sda_sync_reg <= 2'h3;
            scl_prev_reg <= 1'b1;
            sda_prev_reg <= 1'b1;
        end else begin
            scl_sync_reg <= {scl_sync_reg[0], scl_in};
            sda_sync_reg <= {sda_sync_reg[0], sda_in};
            scl_prev_reg <= scl_sync_reg[1];
            sda_prev_reg <= sda_sync_reg[1];
        end
    end

    assign scl_rise   = scl_sync_reg[1] & ~scl_prev_reg;
    assign scl_fall   = ~scl_sync_reg[1] & scl_prev_reg;
    assign start_seen = scl_sync_reg[1] & scl_prev_reg & sda_prev_reg & ~sda_sync_reg[1];
    assign stop_seen  = scl_sync_reg[1] & scl_prev_reg & ~sda_prev_reg & sda_sync_reg[1];
    assign sda_now    = sda_sync_reg[1];

endmodule

// ===== hdl/isam_addr_match.sv
// Purpose: Masked comparison of an incoming address with the own address.
// Assumes: A mask bit of one removes that position from the comparison.
// Notes:   Purely combinational.
`timescale 1ns/100ps
module isam_addr_match (
    input  wire logic [isam_pkg::MASK_W-1:0] in_addr,
    input  wire logic [isam_pkg::MASK_W-1:0] own_addr,
    input  wire logic [isam_pkg::MASK_W-1:0] addr_mask,
    output logic                             match
);

    logic [isam_pkg::MASK_W-1:0] bit_ok;

    genvar i;
    generate
        for (i = 0; i < isam_pkg::MASK_W; i = i + 1) begin : g_bit
            assign bit_ok[i] = addr_mask[i] | (in_addr[i] == own_addr[i]);
        end
    endgenerate

    assign match = &bit_ok;

endmodule

// ===== tb/isam_checker.sv
// Purpose: Port-level checks of the register bus side of isam_top.
// Assumes: hready is tied to hreadyout by the bench.
// Notes:   Flags inside are judged by the bench through reads.
`timescale 1ns/100ps
module isam_checker (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic        sda_o
);
    logic       take;
    logic       rd_reg;
    logic [7:0] off_reg;
    assign take = hsel && hready && htrans[1];
    // The read answer comes a cycle late, so its address is kept here.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rd_reg  <= 1'b0;
            off_reg <= 8'h00;
        end else if (take) begin
            rd_reg  <= !hwrite;
            off_reg <= haddr[7:0];
        end else if (hreadyout) begin
            rd_reg <= 1'b0;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence rd_req; take && !hwrite; endsequence
    sequence rd_ans; !hreadyout ##1 hreadyout; endsequence
    read_wait_a: assert property (rd_req |=> rd_ans)
        else $error("read answer timing wrong");
    write_nowait_a: assert property (take && hwrite |=> hreadyout)
        else $error("write was stalled");
    wait_read_only_a: assert property (!hreadyout |-> rd_reg)
        else $error("stall outside a read");
    rdata_hold_a: assert property (!(rd_reg && !hreadyout) |=> $stable(hrdata))
        else $error("read data moved");
    mask_upper_a: assert property (
        rd_reg && hreadyout && off_reg == isam_pkg::OFF_MASK |-> hrdata[31:10] == 22'h0)
        else $error("mask upper bits not zero");
    status_upper_a: assert property (
        rd_reg && hreadyout && off_reg == isam_pkg::OFF_STATUS |-> hrdata[31:8] == 24'h0)
        else $error("status upper bits not zero");
    okay_resp_a: assert property (hresp == 1'b0) else $error("response not okay");
    sda_low_a: assert property (sda_o == 1'b0) else $error("sda output not low");
endmodule
bind isam_top isam_checker isam_checker_i (
    .clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .sda_o(sda_o));

// ===== tb/isam_bus_model.sv
// Purpose: Master on the two-wire link, driven by task calls.
// Assumes: Both lines have pull-ups; a released line reads high.
// Notes:   SCL stands high between frames; bit period 200 ns.
`timescale 1ns/100ps
module isam_bus_model (
    output logic     scl,
    output logic     sda,
    input wire logic sda_w
);
    initial begin
        scl = 1'b1;
        sda = 1'b1;
    end
    // Pin changes land on clk edges, so they are made non-blocking to avoid a race.
    task start_c;
        sda <= 1'b1;
        #50 scl <= 1'b1;
        #100 sda <= 1'b0;
        #100 scl <= 1'b0;
    endtask
    task stop_c;
        sda <= 1'b0;
        #50 scl <= 1'b1;
        #100 sda <= 1'b1;
        #100;
    endtask
    // One pulse; a one releases SDA so the slave may pull it low.
    task bit_c(input logic o, output logic i);
        #50 sda <= o;
        #50 scl <= 1'b1;
        #50 i = sda_w;
        #50 scl <= 1'b0;
    endtask
    task xfer_byte(input logic [7:0] o, input logic ao, output logic [7:0] i, output logic ai);
        for (int k = 7; k >= 0; k--) bit_c(o[k], i[k]);
        bit_c(ao, ai);
    endtask
endmodule

// ===== tb/isam_top_tb.sv
// Purpose: Register and link tests of the status and mask block.
// Assumes: One AHB-Lite master here and a model master on the link.
// Notes:   Own address 0x2b with mask bit 0 set.
`timescale 1ns/100ps
module isam_top_tb;
    localparam logic [7:0] ST = isam_pkg::OFF_STATUS;
    localparam logic [7:0] MK = isam_pkg::OFF_MASK;
    localparam logic [7:0] TX = isam_pkg::OFF_TXBUF;
    localparam logic [7:0] RX = isam_pkg::OFF_RXBUF;
    logic        clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
    logic [1:0]  htrans = 2'b00;
    logic [2:0]  hsize = 3'b010;
    logic        hreadyout, hresp, scl, sda_m, sda_w, sda_o, sda_oe_n, irq, a;
    logic [7:0]  q;
    int          n_mismatch = 0, checks_done = 0;
    assign sda_w = sda_m & sda_oe_n;
    always #12.5 clk = ~clk;
    isam_top isam_top_i (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .scl_in(scl), .sda_in(sda_w), .sda_o(sda_o),
        .sda_oe_n(sda_oe_n), .irq(irq));
    isam_bus_model isam_bus_model_i (.scl(scl), .sda(sda_m), .sda_w(sda_w));
    ////////////////////////////////////////////////////////////////////////////////
    task end_sim;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // Ready is sampled at the falling edge so the value stands at the next rise.
    task xfer(input logic w, input logic [7:0] ad, input logic [31:0] d, output logic [31:0] v);
        logic r;
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= {24'h0, ad};
        hwrite <= w;
        htrans <= 2'b10;
        do begin @(negedge clk); r = hreadyout; @(posedge clk); end while (r !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do begin @(negedge clk); r = hreadyout; v = hrdata; @(posedge clk); end while (r !== 1'b1);
    endtask
    task rd(input logic [7:0] ad, input logic [31:0] e, input string nm);
        logic [31:0] v;
        xfer(1'b0, ad, 32'h0, v);
        chk(nm, v, e);
    endtask
    task wr(input logic [7:0] ad, input logic [31:0] d);
        logic [31:0] v;
        xfer(1'b1, ad, d, v);
    endtask
    task snd(input logic [7:0] b, input logic e);
        isam_bus_model_i.xfer_byte(b, 1'b1, q, a);
        chk("ack", {31'h0, a}, {31'h0, e});
    endtask
    task irq_is(input logic e);
        @(negedge clk);
        chk("irq", {31'h0, irq}, {31'h0, e});
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #200000;
        n_mismatch++;
        end_sim();
    end
    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        rd(ST, 32'h0, "status");
        rd(MK, 32'h0, "mask");
        wr(MK, 32'hffffffff);
        rd(MK, 32'h3ff, "mask");
        rd(8'h1c, 32'h0, "unmapped");
        wr(MK, 32'h1);
        wr(isam_pkg::OFF_OWNADDR, 32'h2b);
        wr(isam_pkg::OFF_IRQMASK, 32'h3f);
        $display("test registers done");
        isam_bus_model_i.start_c();
        rd(ST, 32'h08, "status");
        snd(8'h54, 1'b0);
        rd(ST, 32'h0a, "status");
        irq_is(1'b1);
        rd(RX, 32'h54, "rxbuf");
        rd(ST, 32'h08, "status");
        snd(8'ha5, 1'b0);
        snd(8'h3c, 1'b0);
        rd(ST, 32'h6a, "status");
        rd(RX, 32'ha5, "rxbuf");
        wr(ST, 32'h40);
        isam_bus_model_i.stop_c();
        rd(ST, 32'h30, "status");
        rd(isam_pkg::OFF_IRQSTAT, 32'h27, "irq status");
        wr(isam_pkg::OFF_IRQSTAT, 32'h3f);
        irq_is(1'b0);
        wr(isam_pkg::OFF_IRQMASK, 32'h0);
        $display("test slave write done");
        isam_bus_model_i.start_c();
        snd(8'h58, 1'b1);
        rd(ST, 32'h08, "status");
        isam_bus_model_i.stop_c();
        $display("test address miss done");
        wr(TX, 32'h9c);
        wr(TX, 32'h33);
        isam_bus_model_i.start_c();
        rd(ST, 32'h89, "status");
        snd(8'h55, 1'b0);
        rd(ST, 32'h8f, "status");
        isam_bus_model_i.xfer_byte(8'hff, 1'b1, q, a);
        chk("tx byte", {24'h0, q}, 32'h9c);
        rd(ST, 32'h8e, "status");
        irq_is(1'b0);
        rd(isam_pkg::OFF_IRQSTAT, 32'h1f, "irq status");
        isam_bus_model_i.stop_c();
        wr(ST, 32'h80);
        rd(ST, 32'h16, "status");
        $display("test slave read done");
        end_sim();
    end
endmodule
